// file: logic/field_eval_defines.svh
`ifndef FIELD_EVAL_DEFINES_SVH
`define FIELD_EVAL_DEFINES_SVH

// Echo limits per measurement for the long and short reach variants.
`define FE_ECHO_MAX_FULL 3'h5
`define FE_ECHO_MAX_RED 3'h2
// Case and field counts.
`define FE_CASES_FULL 10
`define FE_FIELDS_FULL 10
`define FE_CASES_RED 4'h4
`define FE_FIELDS_RED 4'h4
`define FE_OUTPUTS 6
`define FE_INPUTS 4
// Signal strength codes.
`define FE_RSSI_NONE 8'h00
`define FE_RSSI_DAZZLED 8'hFF
// Range at or below which an echo counts as sitting on the exit aperture.
`define FE_APERTURE_RANGE 16'h0032
// Longest output hold time in seconds, and the clock rate in hertz.
`define FE_HOLD_MAX_S 10
`define FE_CLK_HZ 200000000
// Widths of beam index and range.
`define FE_BEAM_W 11
`define FE_RANGE_W 16

`endif

// file: logic/field_eval_pkg.sv
package field_eval_pkg;
`include "field_eval_defines.svh"

   // Echo selection mode.
   typedef enum logic [1:0] {ECHO_FIRST, ECHO_ALL, ECHO_LAST} echo_mode_t;

   // Evaluation strategy of a case.
   typedef enum logic [1:0] {STRAT_PIXEL, STRAT_BLANKING, STRAT_CONTOUR, STRAT_IO_LINK} strategy_t;

   // One echo: range and signal strength code.
   typedef struct packed {
      logic [`FE_RANGE_W-1:0] range;
      logic [7:0] rssi;
   } echo_t;

   // One evaluation field: beam window, range band, blanking size in beams.
   typedef struct packed {
      logic [`FE_BEAM_W-1:0] beam_first;
      logic [`FE_BEAM_W-1:0] beam_last;
      logic [`FE_RANGE_W-1:0] near_limit;
      logic [`FE_RANGE_W-1:0] far_limit;
      logic [7:0] blank_beams;
   } field_cfg_t;

   // One evaluation case.
   typedef struct packed {
      logic enable;
      logic gate_en;
      logic [3:0] gate_code;
      strategy_t strategy;
      logic [3:0] field_sel;
      logic [2:0] out_sel;
      logic [7:0] resp_scans;
      logic tamper_en;
      logic [7:0] tamper_scans;
      logic negate;
      logic [3:0] io_mask;
   } case_cfg_t;

   // One switching output.
   typedef struct packed {
      logic application;
      logic op_and;
      logic active_low;
      logic [31:0] hold_cycles;
      logic release_by_in;
      logic [1:0] release_in;
      logic release_level;
   } out_cfg_t;

endpackage : field_eval_pkg

// file: logic/echo_select.sv
`timescale 1ns/100ps
`default_nettype none

// Picks echoes of one beam by mode and limit; cleans no-signal echoes.
module echo_select (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire field_eval_pkg::echo_mode_t mode,
   input wire logic [2:0] max_echoes,
   input wire logic in_valid,
   input wire field_eval_pkg::echo_t in_echo,
   input wire logic in_last,
   output logic meas_valid,
   output field_eval_pkg::echo_t meas_echo,
   output logic beam_done,
   output field_eval_pkg::echo_t beam_echo
);
   import field_eval_pkg::*;

   logic [2:0] count_r; // Echoes seen so far in this beam.
   echo_t held_r; // Last echo kept for this beam.
   echo_t clean; // Echo with range cleared when there was no signal.
   logic accept; // Echo lies within the variant's limit.
   logic take; // Echo becomes the beam's kept value.

   // A zero strength code carries no valid distance.
   assign clean = (in_echo.rssi == `FE_RSSI_NONE) ? {{`FE_RANGE_W{1'b0}}, in_echo.rssi} : in_echo;
   assign accept = in_valid && (count_r < max_echoes);
   assign take = accept && (mode != ECHO_FIRST || count_r == 3'h0);

   // Echo counter, cleared by the last echo of a beam.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_r <= 3'h0;
      end else if (ce && in_valid) begin
         count_r <= in_last ? 3'h0 : ((count_r == 3'h7) ? count_r : count_r + 3'h1);
      end
   end

   // Kept echo of the beam.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         held_r <= '0;
      end else if (ce && take) begin
         held_r <= clean;
      end
   end

   // Measured value stream and per-beam result.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meas_valid <= 1'b0;
         meas_echo <= '0;
         beam_done <= 1'b0;
         beam_echo <= '0;
      end else if (ce) begin
         // First mode emits the earliest, all mode every accepted, last mode one at the end.
         meas_valid <= (accept && (mode == ECHO_ALL || (mode == ECHO_FIRST && count_r == 3'h0)))
                       || (in_valid && in_last && mode == ECHO_LAST);
         meas_echo <= take ? clean : held_r;
         beam_done <= in_valid && in_last;
         beam_echo <= take ? clean : held_r;
      end
   end

endmodule : echo_select
`default_nettype wire

// file: logic/persist_counter.sv
`timescale 1ns/100ps
`default_nettype none

// Counts consecutive scans in which a condition holds.
module persist_counter #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic step,
   input wire logic cond,
   input wire logic [W-1:0] thresh,
   output logic hit
);
   logic [W-1:0] cnt_r; // Consecutive scans with the condition.
   logic [W-1:0] cnt_inc; // Saturating successor.

   assign cnt_inc = (cnt_r == {W{1'b1}}) ? cnt_r : cnt_r + {{(W-1){1'b0}}, 1'b1};

   // A lapse clears the count; the hit needs the full number of scans.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         hit <= 1'b0;
      end else if (ce && step) begin
         cnt_r <= cond ? cnt_inc : '0;
         hit <= cond && (cnt_inc >= thresh);
      end
   end

   hit_needs_cond_a: assert property (@(posedge clock) disable iff (rst) $rose(hit) |-> $past(cond) && $past(step))
      else $error("Detection rose without its condition.");

endmodule : persist_counter
`default_nettype wire

// file: logic/field_evaluation_logic.sv
`timescale 1ns/100ps
`default_nettype none

// Function
// - Accept five echoes, or two when reduced.
// - First-echo mode keeps only earliest echo.
// - All-echoes mode outputs every echo to limit.
// - Last-echo mode outputs only final echo to limit.
// - Strength code is 8-bit logarithmic, unsigned.
// - Code 255 means dazzled; 1-254 valid.
// - Code 0 means too weak, no distance.
// - Valid distance always has code at least 1.
// - Ten cases and fields, four when reduced.
// - All cases evaluate concurrently every scan.
// - Each case has gate, strategy, field, output, time.
// - Gated case active only on matching inputs.
// - Shared combinations; reduced gates by input one.
// - Pixel strategy flags any beam in field.
// - Blanking ignores objects up to blanking size.
// - Contour flags gaps larger than blanking size.
// - Input link result follows selected inputs.
// - Detection needs persistence for response time.
// - Tamper guard flags aperture objects or glare.
// - AND operator needs all contributing cases.
// - Only application outputs carry case results.
// - Negation inverts the case result.
// - Output operator selectable as AND or OR.
// - Outputs active high by default, or low.
// - Immediate release, hold delay, or input release.
// - Particle filter adds one scan of delay.
module field_evaluation_logic #(
   parameter int NC = `FE_CASES_FULL,
   parameter int NF = `FE_FIELDS_FULL,
   parameter int NO = `FE_OUTPUTS,
   parameter logic [31:0] HOLD_MAX_CYCLES = 32'(64'(`FE_HOLD_MAX_S) * 64'(`FE_CLK_HZ))
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic reduced_variant,
   input wire field_eval_pkg::echo_mode_t echo_mode,
   input wire logic particle_filter_en,
   input wire logic [`FE_INPUTS-1:0] switching_in,
   input wire logic scan_start,
   input wire logic echo_valid,
   input wire field_eval_pkg::echo_t echo_in,
   input wire logic echo_last,
   input wire field_eval_pkg::case_cfg_t case_cfg [NC],
   input wire field_eval_pkg::field_cfg_t field_cfg [NF],
   input wire field_eval_pkg::out_cfg_t out_cfg [NO],
   output logic meas_valid,
   output field_eval_pkg::echo_t meas_echo,
   output logic [NC-1:0] case_result,
   output logic [NO-1:0] switching_out
);
   import field_eval_pkg::*;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // True when the beam lies inside the field's angular window.
   function automatic logic in_window(input field_cfg_t f, input logic [`FE_BEAM_W-1:0] b);
      in_window = (b >= f.beam_first) && (b <= f.beam_last);
   endfunction : in_window

   // True when a beam's echo lands inside the field; no-signal and dazzle never hit.
   function automatic logic field_hit(input field_cfg_t f, input logic [`FE_BEAM_W-1:0] b, input echo_t e);
      field_hit = in_window(f, b) && (e.rssi != `FE_RSSI_NONE) && (e.rssi != `FE_RSSI_DAZZLED)
                  && (e.range >= f.near_limit) && (e.range <= f.far_limit);
   endfunction : field_hit

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------

   logic [`FE_INPUTS-1:0] sync1_r; // First stage, read only by the second.
   logic [`FE_INPUTS-1:0] sync2_r; // Second stage.
   logic [`FE_INPUTS-1:0] sync3_r; // Third stage.
   logic [`FE_INPUTS-1:0] in_lvl_r; // Accepted input levels; bit 0 is the first switching input.

   // Three flops; a level is accepted once the second and third agree.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
         in_lvl_r <= '0;
      end else if (ce) begin
         sync1_r <= switching_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         for (int i = 0; i < `FE_INPUTS; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
               in_lvl_r[i] <= sync3_r[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Echo selection and beam counting
   // ----------------------------------------------------------------

   logic [2:0] echo_limit; // Echo limit for the variant.
   logic beam_done; // One beam's result is ready.
   echo_t beam_echo; // That beam's representative echo.
   logic [`FE_BEAM_W-1:0] beam_r; // Index of the beam being delivered.
   logic [2:0] meas_cnt_r; // Values emitted for the current beam.

   // The reduced variant accepts fewer echoes.
   assign echo_limit = reduced_variant ? `FE_ECHO_MAX_RED : `FE_ECHO_MAX_FULL;

   // Selection of echoes per the mode; strength codes pass through unchanged.
   echo_select u_echo_select (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .mode(echo_mode),
      .max_echoes(echo_limit),
      .in_valid(echo_valid),
      .in_echo(echo_in),
      .in_last(echo_last),
      .meas_valid(meas_valid),
      .meas_echo(meas_echo),
      .beam_done(beam_done),
      .beam_echo(beam_echo)
   );

   // Beam index restarts with each scan and saturates at the top.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         beam_r <= '0;
      end else if (ce) begin
         if (scan_start) begin
            beam_r <= '0;
         end else if (beam_done && beam_r != {`FE_BEAM_W{1'b1}}) begin
            beam_r <= beam_r + {{(`FE_BEAM_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Counts emitted values per beam for the limit check below.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meas_cnt_r <= 3'h0;
      end else if (ce) begin
         if (beam_done) begin
            meas_cnt_r <= 3'h0;
         end else if (meas_valid) begin
            meas_cnt_r <= meas_cnt_r + 3'h1;
         end
      end
   end

   echo_limit_a: assert property (@(posedge clock) disable iff (rst) meas_valid |-> meas_cnt_r < echo_limit)
      else $error("Too many values for one beam.");
   no_signal_range_a: assert property (@(posedge clock) disable iff (rst)
      meas_valid && meas_echo.rssi == `FE_RSSI_NONE |-> meas_echo.range == '0)
      else $error("Distance given without signal.");

   // ----------------------------------------------------------------
   // Evaluation cases, all running side by side
   // ----------------------------------------------------------------

   logic [NC-1:0] case_active; // Case is enabled, within limit and gated in.
   logic [NC-1:0] case_res; // Case result after negation.
   logic [3:0] case_limit; // Cases usable in this variant.
   logic [3:0] field_limit; // Fields usable in this variant.
   logic [3:0] gate_now; // Inputs as a code, first input in the top bit.

   assign case_limit = reduced_variant ? `FE_CASES_RED : 4'(NC);
   assign field_limit = reduced_variant ? `FE_FIELDS_RED : 4'(NF);
   assign gate_now = {in_lvl_r[0], in_lvl_r[1], in_lvl_r[2], in_lvl_r[3]};

   for (genvar c = 0; c < NC; c++) begin : g_case
      field_cfg_t fc; // Field that this case watches.
      logic field_ok; // Selected field exists in this variant.
      logic win; // Current beam lies in the window.
      logic bhit; // Current beam hits the field.
      logic btamp; // Current beam shows glare or an aperture object.
      logic any_r; // Some beam hit this scan.
      logic [7:0] run_r; // Consecutive hit beams.
      logic big_r; // A run exceeded the blanking size.
      logic [7:0] gap_r; // Consecutive beams missing the contour.
      logic gap_big_r; // A gap exceeded the blanking size.
      logic tamp_r; // Tamper sign seen this scan.
      logic cond; // Scan condition for the strategy.
      logic cond_prev_r; // Condition one scan back.
      logic det; // Persistent detection.
      logic tdet; // Persistent tamper sign.
      logic gate_ok; // Inputs select this case.
      logic raw; // Result before negation.

      assign fc = field_cfg[case_cfg[c].field_sel];
      assign field_ok = case_cfg[c].field_sel < field_limit;
      assign win = beam_done && field_ok && in_window(fc, beam_r);
      assign bhit = win && field_hit(fc, beam_r, beam_echo);
      // Glare, or a near echo at the exit aperture, marks tampering.
      assign btamp = win && (beam_echo.rssi == `FE_RSSI_DAZZLED
                     || (beam_echo.rssi != `FE_RSSI_NONE && beam_echo.range <= `FE_APERTURE_RANGE));

      // Per-scan accumulation, cleared at the start of every scan.
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            any_r <= 1'b0;
            run_r <= 8'h00;
            big_r <= 1'b0;
            gap_r <= 8'h00;
            gap_big_r <= 1'b0;
            tamp_r <= 1'b0;
         end else if (ce) begin
            if (scan_start) begin
               any_r <= 1'b0;
               run_r <= 8'h00;
               big_r <= 1'b0;
               gap_r <= 8'h00;
               gap_big_r <= 1'b0;
               tamp_r <= 1'b0;
            end else if (win) begin
               tamp_r <= tamp_r | btamp;
               if (bhit) begin
                  any_r <= 1'b1;
                  run_r <= (run_r == 8'hFF) ? run_r : run_r + 8'h01;
                  gap_r <= 8'h00;
                  // Only objects wider than the blanking size count.
                  if (run_r >= fc.blank_beams) begin
                     big_r <= 1'b1;
                  end
               end else begin
                  run_r <= 8'h00;
                  gap_r <= (gap_r == 8'hFF) ? gap_r : gap_r + 8'h01;
                  // Contour gaps up to the blanking size are tolerated.
                  if (gap_r >= fc.blank_beams) begin
                     gap_big_r <= 1'b1;
                  end
               end
            end
         end
      end

      // Scan condition by strategy.
      always_comb begin
         case (case_cfg[c].strategy)
            STRAT_PIXEL: cond = any_r;
            STRAT_BLANKING: cond = big_r;
            STRAT_CONTOUR: cond = gap_big_r;
            default: cond = 1'b0;
         endcase
      end

      // Particle filter delays the reaction by one scan.
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            cond_prev_r <= 1'b0;
         end else if (ce && scan_start) begin
            cond_prev_r <= cond;
         end
      end

      // Response time in scans for the field strategies.
      persist_counter #(.W(8)) u_resp (
         .clock(clock),
         .rst(rst),
         .ce(ce),
         .step(scan_start),
         .cond(particle_filter_en ? cond_prev_r : cond),
         .thresh(case_cfg[c].resp_scans),
         .hit(det)
      );

      // Tamper guard with its own response time.
      persist_counter #(.W(8)) u_tamper (
         .clock(clock),
         .rst(rst),
         .ce(ce),
         .step(scan_start),
         .cond(case_cfg[c].tamper_en && tamp_r && case_cfg[c].strategy != STRAT_IO_LINK),
         .thresh(case_cfg[c].tamper_scans),
         .hit(tdet)
      );

      // Full variant matches all four inputs; reduced uses only the first.
      assign gate_ok = !case_cfg[c].gate_en
                       || (reduced_variant ? (case_cfg[c].gate_code[3] == in_lvl_r[0])
                                           : (case_cfg[c].gate_code == gate_now));
      assign case_active[c] = case_cfg[c].enable && (4'(c) < case_limit) && gate_ok;
      // Input link follows the selected inputs directly.
      assign raw = (case_cfg[c].strategy == STRAT_IO_LINK) ? |(case_cfg[c].io_mask & in_lvl_r) : (det | tdet);
      assign case_res[c] = raw ^ case_cfg[c].negate;

      // Registered status of each active case.
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            case_result[c] <= 1'b0;
         end else if (ce) begin
            case_result[c] <= case_active[c] && case_res[c];
         end
      end

      gate_match_a: assert property (@(posedge clock) disable iff (rst)
         $rose(case_result[c]) && $past(case_cfg[c].gate_en && !reduced_variant) |-> $past(case_cfg[c].gate_code == gate_now))
         else $error("Gated case active on wrong inputs.");
   end

   // ----------------------------------------------------------------
   // Switching outputs
   // ----------------------------------------------------------------

   for (genvar o = 0; o < NO; o++) begin : g_out
      logic or_v; // Some contributing case signals.
      logic and_v; // Every contributing case signals.
      logic any_v; // At least one case contributes.
      logic sw; // Combined request for this output.
      logic on_r; // Output logically active.
      logic on_nxt; // Next value of on_r.
      logic [31:0] hold_r; // Remaining hold cycles.
      logic [31:0] hold_set; // Hold time clamped to its ceiling.

      // Combine contributing cases with the output's operator.
      always_comb begin
         or_v = 1'b0;
         and_v = 1'b1;
         any_v = 1'b0;
         for (int c = 0; c < NC; c++) begin
            if (case_active[c] && case_cfg[c].out_sel == 3'(o)) begin
               any_v = 1'b1;
               or_v = or_v | case_res[c];
               and_v = and_v & case_res[c];
            end
         end
      end

      // Only application outputs carry case results.
      assign sw = out_cfg[o].application && any_v && (out_cfg[o].op_and ? and_v : or_v);
      assign hold_set = (out_cfg[o].hold_cycles > HOLD_MAX_CYCLES) ? HOLD_MAX_CYCLES : out_cfg[o].hold_cycles;

      // Release immediately, after the hold, or when the chosen input reaches its level.
      always_comb begin
         on_nxt = on_r;
         if (sw) begin
            on_nxt = 1'b1;
         end else if (out_cfg[o].release_by_in) begin
            if (in_lvl_r[out_cfg[o].release_in] == out_cfg[o].release_level) begin
               on_nxt = 1'b0;
            end
         end else if (hold_r == 32'h0000_0000) begin
            on_nxt = 1'b0;
         end
      end

      // Output state, hold counter and pin level with its polarity.
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            on_r <= 1'b0;
            hold_r <= 32'h0000_0000;
            switching_out[o] <= 1'b0;
         end else if (ce) begin
            on_r <= on_nxt;
            switching_out[o] <= on_nxt ^ out_cfg[o].active_low;
            if (sw) begin
               hold_r <= hold_set;
            end else if (hold_r != 32'h0000_0000) begin
               hold_r <= hold_r - 32'h0000_0001;
            end
         end
      end

      and_all_a: assert property (@(posedge clock) disable iff (rst)
         $rose(on_r) && $past(out_cfg[o].op_and) |-> $past(and_v && any_v))
         else $error("AND output switched without all cases.");
      app_only_a: assert property (@(posedge clock) disable iff (rst)
         $rose(on_r) |-> $past(out_cfg[o].application))
         else $error("Non-application output switched.");
      pin_polarity_a: assert property (@(posedge clock) disable iff (rst)
         $past(ce) |-> switching_out[o] == (on_r ^ $past(out_cfg[o].active_low)))
         else $error("Output polarity wrong.");
      hold_release_a: assert property (@(posedge clock) disable iff (rst)
         ce && on_r && !sw && !out_cfg[o].release_by_in && hold_r == 32'h0000_0000 |=> !on_r)
         else $error("Output not released after hold.");
   end

endmodule : field_evaluation_logic
`default_nettype wire

// file: bench/switch_partner.sv
`timescale 1ns/100ps
`default_nettype none
// Drives the switching input pins from a combination code.
module switch_partner (
   input wire logic [3:0] combo,
   output logic [3:0] pins
);
   // Code bit 3 is input 1, which sits on pin bit 0.
   assign pins = {combo[0], combo[1], combo[2], combo[3]};
endmodule : switch_partner
`default_nettype wire

// file: bench/test_field_evaluation_logic.sv
`timescale 1ns/100ps
`default_nettype none
module test_field_evaluation_logic;
   import field_eval_pkg::*;
   logic clock = 0, rst = 1, ce = 1, red = 0, pf = 0, ss = 0, ev = 0, el = 0, mv;
   echo_mode_t mode = ECHO_ALL;
   echo_t ein = '0, me, last_me, ec [6];
   logic [3:0] combo = 4'h0, pins;
   logic [9:0] cr;
   logic [5:0] so;
   case_cfg_t cc [10] = '{default: '0};
   field_cfg_t fc [10] = '{default: '0};
   out_cfg_t oc [6] = '{default: '0};
   logic [31:0] seed = 32'h033A;
   int fail_count = 0, checked = 0, cyc = 0, nmeas = 0;
   // Clock and the timeout watch; measured values are counted here.
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (mv === 1'b1) begin
         nmeas++;
         last_me = me;
      end
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   switch_partner part_u (.combo(combo), .pins(pins));
   field_evaluation_logic #(.HOLD_MAX_CYCLES(32'h0000_0040)) dut_u (.clock(clock), .rst(rst), .ce(ce),
      .reduced_variant(red), .echo_mode(mode), .particle_filter_en(pf), .switching_in(pins),
      .scan_start(ss), .echo_valid(ev), .echo_in(ein), .echo_last(el), .case_cfg(cc),
      .field_cfg(fc), .out_cfg(oc), .meas_valid(mv), .meas_echo(me), .case_result(cr),
      .switching_out(so));
   function logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction : xs
   // Number of values output for a beam of n echoes.
   function int exp_n(echo_mode_t m, int n, logic r);
      int lim;
      lim = r ? 2 : 5;
      return (m != ECHO_ALL) ? 1 : ((n > lim) ? lim : n);
   endfunction : exp_n
   // A no-signal echo carries no distance.
   function echo_t clean(echo_t e);
      return (e.rssi == 8'h00) ? '0 : e;
   endfunction : clean
   task tick(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task cmp(string name, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp
   task beam(int n);
      for (int i = 0; i < n; i++) begin
         ein = ec[i];
         ev = 1;
         el = (i == n - 1);
         tick(1);
      end
      ev = 0;
      el = 0;
      tick(4);
   endtask : beam
   task scan();
      ss = 1;
      tick(1);
      ss = 0;
      tick(2);
   endtask : scan
   task final_report();
      if (fail_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   initial begin
      int k;
      tick(10);
      rst = 0;
      tick(3);
      // Echo selection over variants, modes and beam sizes.
      for (int r = 0; r < 2; r++)
         for (int m = 0; m < 3; m++)
            for (int n = 1; n < 7; n += 5 - 3 * (n / 3)) begin
               red = r[0];
               mode = echo_mode_t'(m);
               foreach (ec[i]) begin
                  seed = xs(seed);
                  ec[i] = '{seed[31:16], (i == 1) ? 8'h00 : (seed[7:0] | 8'h01)};
               end
               k = (m == 0) ? 0 : exp_n(ECHO_ALL, n, r[0]) - 1;
               nmeas = 0;
               beam(n);
               cmp("meas count", exp_n(mode, n, red), nmeas);
               cmp("meas echo", clean(ec[k]), last_me);
            end
      red = 0;
      mode = ECHO_ALL;
      // Input link case on output 0 with polarity, negation and gating.
      cc[0] = '{1'b1, 1'b0, 4'h0, STRAT_IO_LINK, 4'h0, 3'h0, 8'h01, 1'b0, 8'h01, 1'b0, 4'h1};
      oc[0].application = 1;
      combo = 4'h8;
      tick(8);
      cmp("io result", 2'b11, {cr[0], so[0]});
      oc[0].active_low = 1;
      tick(4);
      cmp("active low", 1'b0, so[0]);
      cc[0].negate = 1;
      tick(4);
      cmp("negated", 2'b01, {cr[0], so[0]});
      cc[0].negate = 0;
      oc[0] = '0;
      tick(4);
      cmp("not application", 1'b0, so[0]);
      oc[0].application = 1;
      cc[0].gate_en = 1;
      cc[0].gate_code = 4'h9;
      combo = 4'h9;
      tick(8);
      cmp("gate match", 1'b1, cr[0]);
      combo = 4'h8;
      tick(8);
      cmp("gate miss", 1'b0, cr[0]);
      // Pixel case on output 1 needing two scans.
      fc[0] = '{11'h000, 11'h003, 16'h0064, 16'h03E8, 8'h00};
      ec[0] = '{16'h01F4, 8'h50};
      scan();
      cc[1] = '{1'b1, 1'b0, 4'h0, STRAT_PIXEL, 4'h0, 3'h1, 8'h02, 1'b0, 8'h01, 1'b0, 4'h0};
      oc[1].application = 1;
      scan();
      beam(1);
      scan();
      tick(2);
      cmp("one scan", 1'b0, cr[1]);
      beam(1);
      scan();
      tick(2);
      cmp("two scans", 2'b11, {cr[1], so[1]});
      // Particle filter: an empty scan still sees the previous hit once.
      pf = 1;
      scan();
      tick(2);
      cmp("filter delay", 1'b1, cr[1]);
      scan();
      tick(2);
      cmp("filter clear", 1'b0, cr[1]);
      // AND of two input link cases on output 0, then a hold of 16 cycles.
      cc[0].gate_en = 0;
      cc[2] = '{1'b1, 1'b0, 4'h0, STRAT_IO_LINK, 4'h0, 3'h0, 8'h01, 1'b0, 8'h01, 1'b0, 4'h2};
      oc[0].op_and = 1;
      oc[0].hold_cycles = 32'h0000_0010;
      tick(8);
      cmp("and one", 1'b0, so[0]);
      combo = 4'hC;
      tick(8);
      cmp("and all", 1'b1, so[0]);
      combo = 4'h8;
      tick(6);
      cmp("hold on", 1'b1, so[0]);
      tick(20);
      cmp("hold off", 1'b0, so[0]);
      final_report();
   end
endmodule : test_field_evaluation_logic
`default_nettype wire
